// File: hw/embi_defines.vh
// constants shared by the external memory bus interface files
`ifndef EMBI_DEFINES_VH
`define EMBI_DEFINES_VH

// ************************************************************
// bus configuration field layout
// ************************************************************
`define EMBI_CFG_W        8
`define EMBI_CFG_WS_HI    1
`define EMBI_CFG_WS_LO    0
`define EMBI_CFG_WIDE     6
`define EMBI_CFG_DEMUX    7
`define EMBI_REGIONS      4
`define EMBI_REGION_W     2
`define EMBI_CFG_ALL_W    32

// ************************************************************
// bus widths
// ************************************************************
`define EMBI_ADDR_W       20
`define EMBI_DATA_W       16
`define EMBI_BYTE_W       8

// ************************************************************
// timing in reference clock cycles
// ************************************************************
`define EMBI_CNT_W        4
`define EMBI_OSC_PER_WS   4'h2
`define EMBI_STRB_BASE    4'h2
`define EMBI_CNT_ONE      4'h1
`define EMBI_CNT_ZERO     4'h0

`endif

// File: hw/embi_top.v
// external memory bus controller: mux/demux read and write cycles
`timescale 1ns/1ps
`include "embi_defines.vh"

module embi_top (
  input  wire                        REF_CLK,
  input  wire                        RST,
  input  wire                        CE,
  input  wire                        REQ,
  input  wire                        WR,
  input  wire [`EMBI_REGION_W-1:0]   REGION,
  input  wire [`EMBI_ADDR_W-1:0]     ADDR,
  input  wire [`EMBI_DATA_W-1:0]     WDATA,
  input  wire [`EMBI_CFG_ALL_W-1:0]  BUS_CONFIG,
  input  wire                        READY_EN,
  input  wire                        READY,
  input  wire [`EMBI_DATA_W-1:0]     AD_IN,
  output reg  [`EMBI_DATA_W-1:0]     AD_OUT,
  output reg                         AD_OE,
  output reg  [`EMBI_ADDR_W-1:0]     ADDR_OUT,
  output reg                         ALE,
  output reg  [`EMBI_REGIONS-1:0]    CS_N,
  output reg                         RD_N,
  output reg                         WR_N,
  output reg  [`EMBI_DATA_W-1:0]     RDATA,
  output reg                         DONE,
  output reg                         BUSY
);

  // ************************************************************
  // states
  // ************************************************************
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_ADDR  = 5'h02;
  localparam [4:0] ST_LATCH = 5'h04;
  localparam [4:0] ST_STRB  = 5'h08;
  localparam [4:0] ST_HOLD  = 5'h10;

  // ************************************************************
  // functions
  // ************************************************************
  function [`EMBI_CFG_W-1:0] cfg_of;
    input [`EMBI_CFG_ALL_W-1:0] all;
    input [`EMBI_REGION_W-1:0]  idx;
    begin
      cfg_of = all[idx*`EMBI_CFG_W +: `EMBI_CFG_W];
    end
  endfunction

  function [`EMBI_REGIONS-1:0] cs_low;
    input [`EMBI_REGION_W-1:0] idx;
    reg   [`EMBI_REGIONS-1:0]  one;
    begin
      one    = {{(`EMBI_REGIONS-1){1'b0}}, 1'b1};
      cs_low = ~(one << idx);
    end
  endfunction

  // base strobe plus two cycles for each wait state
  function [`EMBI_CNT_W-1:0] strb_len;
    input [1:0] ws;
    begin
      strb_len = `EMBI_STRB_BASE + ({2'b00, ws} * `EMBI_OSC_PER_WS);
    end
  endfunction

  function [`EMBI_DATA_W-1:0] lane_mask;
    input                     wide;
    input [`EMBI_DATA_W-1:0]  d;
    begin
      if (wide) begin
        lane_mask = d;
      end else begin
        lane_mask = {{`EMBI_BYTE_W{1'b0}}, d[`EMBI_BYTE_W-1:0]};
      end
    end
  endfunction

  // ************************************************************
  // input synchronisers
  // ************************************************************
  reg [`EMBI_DATA_W-1:0] ad_in_s1_reg;
  reg [`EMBI_DATA_W-1:0] ad_in_s2_reg;
  reg                    ready_s1_reg;
  reg                    ready_s2_reg;

  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ad_in_s1_reg <= {`EMBI_DATA_W{1'b0}};
      ad_in_s2_reg <= {`EMBI_DATA_W{1'b0}};
      ready_s1_reg <= 1'b1;
      ready_s2_reg <= 1'b1;
    end else if (CE) begin
      ad_in_s1_reg <= AD_IN;
      ad_in_s2_reg <= ad_in_s1_reg;
      ready_s1_reg <= READY;
      ready_s2_reg <= ready_s1_reg;
    end
  end

  // ************************************************************
  // cycle state
  // ************************************************************
  reg [4:0]                  state_reg;
  reg                        wr_reg;
  reg                        demux_reg;
  reg                        wide_reg;
  reg                        rdy_en_reg;
  reg [1:0]                  ws_reg;
  reg [`EMBI_DATA_W-1:0]     wdata_reg;
  reg [`EMBI_CFG_W-1:0]      cfg_sel;

  wire ctr_load;
  wire ctr_dec;
  wire ctr_expired;
  wire ready_stall;

  always @* begin
    cfg_sel = cfg_of(BUS_CONFIG, REGION);
  end

  // slow memory holds ready low to stretch a multiplexed cycle
  assign ready_stall = !demux_reg && rdy_en_reg && !ready_s2_reg;
  assign ctr_load    = (state_reg == ST_LATCH);
  assign ctr_dec     = (state_reg == ST_STRB) && !ctr_expired;

  embi_wait_ctr u_wait_ctr (
    .clk      (REF_CLK),
    .rst      (RST),
    .ce       (CE),
    .load     (ctr_load),
    .load_val (strb_len(ws_reg)),
    .dec      (ctr_dec),
    .expired  (ctr_expired)
  );

  // ************************************************************
  // bus sequencer
  // ************************************************************
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_reg  <= ST_IDLE;
      wr_reg     <= 1'b0;
      demux_reg  <= 1'b0;
      wide_reg   <= 1'b0;
      rdy_en_reg <= 1'b0;
      ws_reg     <= 2'b00;
      wdata_reg  <= {`EMBI_DATA_W{1'b0}};
      AD_OUT     <= {`EMBI_DATA_W{1'b0}};
      AD_OE      <= 1'b0;
      ADDR_OUT   <= {`EMBI_ADDR_W{1'b0}};
      ALE        <= 1'b0;
      CS_N       <= {`EMBI_REGIONS{1'b1}};
      RD_N       <= 1'b1;
      WR_N       <= 1'b1;
      RDATA      <= {`EMBI_DATA_W{1'b0}};
      DONE       <= 1'b0;
      BUSY       <= 1'b0;
    end else if (CE) begin
      DONE <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (REQ) begin
            wr_reg     <= WR;
            ws_reg     <= cfg_sel[`EMBI_CFG_WS_HI:`EMBI_CFG_WS_LO];
            demux_reg  <= cfg_sel[`EMBI_CFG_DEMUX];
            wide_reg   <= cfg_sel[`EMBI_CFG_WIDE];
            rdy_en_reg <= READY_EN;
            wdata_reg  <= lane_mask(cfg_sel[`EMBI_CFG_WIDE], WDATA);
            ADDR_OUT   <= ADDR;
            CS_N       <= cs_low(REGION);
            BUSY       <= 1'b1;
            if (!cfg_sel[`EMBI_CFG_DEMUX]) begin
              // address goes out on the shared pins first
              AD_OUT <= ADDR[`EMBI_DATA_W-1:0];
              AD_OE  <= 1'b1;
              ALE    <= 1'b1;
            end
            state_reg <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          // latch strobe falls while address still sits on the pins
          ALE       <= 1'b0;
          state_reg <= ST_LATCH;
        end
        ST_LATCH: begin
          // address leaves the shared pins in the same cycle the strobe falls
          AD_OUT    <= wdata_reg;
          AD_OE     <= wr_reg;
          RD_N      <= wr_reg;
          WR_N      <= !wr_reg;
          state_reg <= ST_STRB;
        end
        ST_STRB: begin
          if (ctr_expired && !ready_stall) begin
            RD_N      <= 1'b1;
            WR_N      <= 1'b1;
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // synchroniser output was sampled while the strobe was still low
          if (!wr_reg) begin
            RDATA <= lane_mask(wide_reg, ad_in_s2_reg);
          end
          // chip select ends only after data was taken
          CS_N      <= {`EMBI_REGIONS{1'b1}};
          AD_OE     <= 1'b0;
          DONE      <= 1'b1;
          BUSY      <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// File: hw/embi_wait_ctr.v
// strobe length counter: loaded at strobe start, counts down to one
`timescale 1ns/1ps
`include "embi_defines.vh"

module embi_wait_ctr (
  input  wire                   clk,
  input  wire                   rst,
  input  wire                   ce,
  input  wire                   load,
  input  wire [`EMBI_CNT_W-1:0] load_val,
  input  wire                   dec,
  output wire                   expired
);

  reg [`EMBI_CNT_W-1:0] count_reg;
  reg [`EMBI_CNT_W-1:0] count_next;

  always @* begin
    count_next = count_reg;
    if (load) begin
      count_next = load_val;
    end else if (dec && (count_reg != `EMBI_CNT_ZERO)) begin
      count_next = count_reg - `EMBI_CNT_ONE;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= `EMBI_CNT_ZERO;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end

  assign expired = (count_reg == `EMBI_CNT_ONE);

endmodule

// File: tb/embi_flash.sv
// flash memory model with address latch and ready output
`timescale 1ns/1ps
module embi_flash (
  input  wire        clk,
  input  wire [3:0]  cs_n,
  input  wire        rd_n,
  input  wire        wr_n,
  input  wire        ale,
  input  wire        mux,
  input  wire [3:0]  stall,
  input  wire [19:0] addr,
  input  wire [15:0] ad_out,
  input  wire        ad_oe,
  output wire [15:0] ad_in,
  output wire        ready
);
  reg  [15:0] mem [0:15];
  reg  [15:0] lat;
  reg  [15:0] last = 16'h0000;
  reg  [3:0]  wcnt = 4'h0;
  wire        sel = (cs_n != 4'hF);
  wire [3:0]  a = mux ? lat[3:0] : addr[3:0];
  // released pins show a pattern that changes every cycle
  assign ad_in = ad_oe ? ad_out : (sel && !rd_n) ? mem[a] : ~last;
  assign ready = (wcnt >= stall);
  always @*
    if (ale)
      lat = ad_out;
  always @(posedge clk) begin
    last <= ad_in;
    wcnt <= rd_n ? 4'h0 : wcnt + 4'h1;
  end
  always @(posedge wr_n)
    if (sel)
      mem[a] <= ad_out;
endmodule

// File: tb/embi_props_properties.sv
// port checker for the external memory bus interface
`timescale 1ns/1ps
module embi_props (
  input wire        REF_CLK,
  input wire        RST,
  input wire        CE,
  input wire        REQ,
  input wire        WR,
  input wire [1:0]  REGION,
  input wire [15:0] WDATA,
  input wire [31:0] BUS_CONFIG,
  input wire        READY_EN,
  input wire [15:0] AD_OUT,
  input wire        AD_OE,
  input wire [19:0] ADDR_OUT,
  input wire        ALE,
  input wire [3:0]  CS_N,
  input wire        RD_N,
  input wire        WR_N,
  input wire [15:0] RDATA,
  input wire        DONE,
  input wire        BUSY
);
  reg  [7:0] cfg_reg;
  reg        wr_reg;
  reg        ren_reg;
  reg  [7:0] wd_reg;
  reg  [3:0] cnt_reg;
  wire [3:0] len = {1'b0, cfg_reg[1:0], 1'b0} + 4'h2;
  wire       fix = !(ren_reg && !cfg_reg[7]);
  // region settings captured at accept, strobe low cycles counted
  always @(posedge REF_CLK) begin
    if (CE && REQ && !BUSY) begin
      cfg_reg <= BUS_CONFIG[8 * REGION +: 8];
      wr_reg <= WR;
      ren_reg <= READY_EN;
      wd_reg <= WDATA[7:0];
    end
    if (CE)
      cnt_reg <= (RD_N && WR_N) ? 4'h0 : cnt_reg + 4'h1;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  AST_RD_LEN: assert property (
    $rose(RD_N) && fix |-> cnt_reg == len)
    else $error("read strobe length wrong");
  AST_WR_LEN: assert property (
    $rose(WR_N) && fix |-> cnt_reg == len)
    else $error("write strobe length wrong");
  AST_RD_END: assert property (
    $rose(RD_N) |=> DONE && CS_N == 4'hF)
    else $error("read end without done");
  AST_RD_CS: assert property (
    !RD_N |-> CS_N != 4'hF && !AD_OE)
    else $error("read strobe without select or pins driven");
  AST_ALE_ADDR: assert property (
    ALE |-> AD_OE && AD_OUT == ADDR_OUT[15:0] ##1 !ALE && $stable(AD_OUT))
    else $error("address not valid around latch strobe fall");
  AST_ALE_MUX: assert property (
    ALE |-> !cfg_reg[7] && BUSY)
    else $error("latch strobe outside multiplexed cycle");
  AST_ADDR_FIRST: assert property (
    $fell(RD_N) && !cfg_reg[7] |-> $past(ALE, 2))
    else $error("no address phase before data");
  AST_WR_DATA: assert property (
    !WR_N |-> AD_OE && AD_OUT[7:0] == wd_reg)
    else $error("write data not on pins");
  AST_NARROW: assert property (
    DONE && !wr_reg && !cfg_reg[6] |-> RDATA[15:8] == 8'h00)
    else $error("upper byte set in narrow read");
  AST_RDY_MIN: assert property (
    $rose(RD_N) && !fix |-> cnt_reg >= len)
    else $error("ready stretched strobe too short");
  cover property ($rose(RD_N) && cfg_reg[1:0] == 2'h3);
  cover property (ALE);
  cover property ($rose(RD_N) && !fix && cnt_reg > len);
endmodule

bind embi_top embi_props i_props (.*);

// File: tb/tb_top.sv
// testbench for the external memory bus interface
`timescale 1ns/1ps
module tb_top;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         req = 1'b0;
  reg         ce = 1'b1;
  wire        busy;
  reg         wr = 1'b0;
  reg         ren = 1'b0;
  reg  [1:0]  rgn = 2'h0;
  reg  [15:0] wd = 16'h0000;
  reg  [31:0] cfg = 32'h0;
  reg  [3:0]  stall = 4'h0;
  wire [15:0] ad_in;
  wire [15:0] ad_out;
  wire [19:0] a_out;
  wire [15:0] rdat;
  wire [3:0]  cs_n;
  wire        ad_oe;
  wire        ale;
  wire        rd_n;
  wire        wr_n;
  wire        done;
  wire        rdy;
  wire        mux = !cfg[8 * rgn + 7];
  integer     n_mismatch = 0;
  integer     checked = 0;
  integer     cyc;
  initial begin
    forever #5 clk = ~clk;
  end
  embi_top i_dut (.REF_CLK(clk), .RST(rst), .CE(ce), .REQ(req),
    .WR(wr), .REGION(rgn), .ADDR({4'hA, wd}), .WDATA(wd),
    .BUS_CONFIG(cfg), .READY_EN(ren), .READY(rdy), .AD_IN(ad_in),
    .AD_OUT(ad_out), .AD_OE(ad_oe), .ADDR_OUT(a_out), .ALE(ale),
    .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .RDATA(rdat),
    .DONE(done), .BUSY(busy));
  embi_flash i_mem (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .ale(ale), .mux(mux), .stall(stall), .addr(a_out),
    .ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in), .ready(rdy));
  task results;
    begin
      $display("checked=%0d mismatches=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // cyc counts edges from accept to done
  task wait_done;
    begin
      for (cyc = 0; cyc < 60 && done !== 1'b1; cyc = cyc + 1) begin
        @(posedge clk);
        #1;
      end
      if (cyc == 60) begin
        n_mismatch = n_mismatch + 1;
        results;
      end
    end
  endtask
  // one access
  task acc(input w, input [1:0] r, input [7:0] c, input [15:0] d,
    input e);
    begin
      @(posedge clk);
      wr <= w;
      rgn <= r;
      wd <= d;
      cfg <= {24'h0, c} << (8 * r);
      ren <= e;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      wait_done;
    end
  endtask
  task t_ws;
    integer m;
    integer s;
    begin
      for (m = 0; m < 2; m = m + 1)
        for (s = 0; s < 4; s = s + 1) begin
          acc(1'b1, s[1:0], {m[0], 3'h4, 2'h0, s[1:0]},
            {12'hC3A, m[1:0], s[1:0]}, 1'b0);
          chk(cyc, 5 + 2 * s);
          acc(1'b0, s[1:0], {m[0], 3'h4, 2'h0, s[1:0]},
            {12'hC3A, m[1:0], s[1:0]}, 1'b0);
          chk(cyc, 5 + 2 * s);
          chk(rdat, {12'hC3A, m[1:0], s[1:0]});
        end
    end
  endtask
  task t_width;
    begin
      acc(1'b0, 2'h1, 8'h81, 16'hC3A5, 1'b0);
      chk(rdat, 16'h00A5);
    end
  endtask
  task t_rdy;
    begin
      stall <= 4'h6;
      acc(1'b0, 2'h2, 8'h41, 16'hC3A1, 1'b1);
      chk(cyc > 7, 1);
      chk(rdat, 16'hC3A1);
      acc(1'b0, 2'h2, 8'h41, 16'hC3A1, 1'b0);
      chk(cyc, 7);
      acc(1'b0, 2'h2, 8'hC1, 16'hC3A1, 1'b1);
      chk(cyc, 7);
    end
  endtask
  // request held while the clock enable is low waits for it
  task t_ce;
    begin
      @(posedge clk);
      ce <= 1'b0;
      wr <= 1'b0;
      rgn <= 2'h3;
      wd <= 16'hC3A2;
      cfg <= 32'hC0000000;
      ren <= 1'b0;
      req <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk({busy, cs_n}, 5'h0F);
      @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      wait_done;
      chk(cyc, 5);
      chk(rdat, 16'hC3A2);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_ws;
    t_width;
    t_rdy;
    t_ce;
    results;
  end
endmodule
